/* File: dv/pwm_chk_sva.sv */
// Checker for the pwm channel: restart, first period, event, update, lag.
// Assumes one clock; checks pause while ce_i is low or reset is high.
`timescale 1ns/1ps
module pwm_chk_sva (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic enable_i,
   input wire logic disable_i,
   input wire logic center_align_select_i,
   input wire logic period_wr_i,
   input wire logic update_wr_i,
   input wire logic [15:0] update_wdata_i,
   input wire logic channel_enabled_status_o,
   input wire logic event_o,
   input wire logic [15:0] period_value_o,
   input wire logic [15:0] count_o
);
   // One domain; a stopped counter is told apart by a frozen count
   default clocking @(posedge clock_i); endclocking
   default disable iff (srst_i || !ce_i);
   first_zero_a: assert property ($rose(channel_enabled_status_o) |-> ##[1:3] count_o == 16'h0000)
      else $error("first period not from zero");
   restart_one_a: assert property (!center_align_select_i && count_o == period_value_o
      && count_o != 16'h0000 && count_o != $past(count_o)
      && !$past(disable_i) && !$past(disable_i, 2) |=> count_o == 16'h0001)
      else $error("restart not at one");
   center_event_a: assert property (enable_i && center_align_select_i
      && !channel_enabled_status_o |=> event_o) else $error("no event on center enable");
   zero_update_a: assert property (update_wr_i && update_wdata_i == 16'h0000 && !period_wr_i
      && !channel_enabled_status_o && !$past(update_wr_i) |=> $stable(period_value_o))
      else $error("zero update applied");
   update_hold_a: assert property (channel_enabled_status_o && count_o != $past(count_o)
      && count_o + 16'h0002 <= period_value_o && !period_wr_i
      && !$past(disable_i) && !$past(disable_i, 2)
      && (!center_align_select_i || count_o > 16'h0002) |=> $stable(period_value_o))
      else $error("update applied mid period");
   status_lag_a: assert property (disable_i && !enable_i && channel_enabled_status_o
      && period_value_o != 16'h0000 && count_o != $past(count_o)
      |=> channel_enabled_status_o [*2]) else $error("status dropped early");
endmodule
bind pwm_channel_period_counter pwm_chk_sva chk_u (.clock_i(clock_i), .srst_i(srst_i),
   .ce_i(ce_i),
   .enable_i(enable_i), .disable_i(disable_i), .center_align_select_i(center_align_select_i),
   .period_wr_i(period_wr_i), .update_wr_i(update_wr_i), .update_wdata_i(update_wdata_i),
   .channel_enabled_status_o(channel_enabled_status_o), .event_o(event_o),
   .period_value_o(period_value_o), .count_o(count_o));

/* File: dv/tb_top.sv */
// Bench for the pwm channel period counter, driving its ports directly.
// Assumes package, interface and design compiled first.
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0, rst = 1'b1, en = 1'b0, dis = 1'b0, ctr = 1'b0, pwr = 1'b0;
   logic uwr = 1'b0, clr = 1'b0, ce = 1'b1, pwm, st, ev;
   logic [15:0] pwd = 16'h0000, uwd = 16'h0000, pv, cnt;
   int error_cnt = 0, comparisons = 0, n, i;
   // Strobe masks for pulse, bit order {clr, uwr, pwr, dis, en}
   localparam logic [4:0] SEL_EN = 5'h01, SEL_DIS = 5'h02, SEL_PWR = 5'h04, SEL_UWR = 5'h08;
   localparam logic [4:0] SEL_CLR = 5'h10;
   pwm_channel_period_counter dut_u (.clock_i(clk), .srst_i(rst), .ce_i(ce),
      .enable_i(en), .disable_i(dis), .center_align_select_i(ctr), .period_wr_i(pwr),
      .period_wdata_i(pwd), .update_wr_i(uwr), .update_wdata_i(uwd), .duty_i(16'h0002),
      .event_clr_i(clr), .pwm_o(pwm), .channel_enabled_status_o(st), .event_o(ev),
      .period_value_o(pv), .count_o(cnt));
   // 250 MHz clock
   initial begin
      forever #2 clk = ~clk;
   end
   task automatic summarize();
      $display("comparisons=%0d errors=%0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   // Strobes and data change at an edge, held one edge; returns just after the taking edge
   task automatic pulse(input logic [4:0] m, input logic [15:0] d);
      @(posedge clk);
      {clr, uwr, pwr, dis, en} <= m;
      pwd <= d;
      uwd <= d;
      @(posedge clk);
      {clr, uwr, pwr, dis, en} <= 5'h00;
      #1;
   endtask
   // Disable, then count status cycles; bounded so a stuck bit ends the run
   task automatic stop();
      pulse(SEL_DIS, 16'h0000);
      n = 0;
      while (st === 1'b1 && n < 60) begin
         n++;
         tick(1);
      end
      if (n == 60) begin
         error_cnt++;
         summarize();
      end
   endtask
   task automatic t_left();
      pulse(SEL_PWR, 16'h0005);
      pulse(SEL_EN, 16'h0000);
      tick(2);
      for (i = 0; i < 11; i++) begin
         chk(cnt, 16'((i < 6) ? i : i - 5));
         chk(16'(pwm), 16'(((i < 6) ? i : i - 5) < 2));
         tick(1);
      end
      // Clock enable low for four edges: the count must hold, then resume
      @(posedge clk);
      ce <= 1'b0;
      tick(3);
      chk(cnt, 16'h0002);
      @(posedge clk);
      ce <= 1'b1;
      tick(2);
      chk(cnt, 16'h0004);
      stop();
      chk(16'(n), 16'h0006);
      $display("left aligned done");
   endtask
   task automatic t_update();
      pulse(SEL_UWR, 16'h0000);
      chk(pv, 16'h0005);
      pulse(SEL_UWR, 16'h0003);
      pulse(SEL_EN, 16'h0000);
      pulse(SEL_UWR, 16'h0007);
      chk(pv, 16'h0003);
      tick(6);
      chk(pv, 16'h0007);
      stop();
      chk(16'(n), 16'h0008);
      pulse(SEL_PWR, 16'h0000);
      chk(pv, 16'h0000);
      $display("update path done");
   endtask
   task automatic t_center();
      pulse(SEL_PWR, 16'h0004);
      pulse(SEL_CLR, 16'h0000);
      @(posedge clk);
      ctr <= 1'b1;
      pulse(SEL_EN, 16'h0000);
      chk(16'(ev), 16'h0001);
      pulse(SEL_CLR, 16'h0000);
      chk(16'(ev), 16'h0000);
      stop();
      chk(16'(n), 16'h0005);
      $display("center event done");
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_left();
      t_update();
      t_center();
      summarize();
   end
endmodule

/* File: hw/pwm_channel_period_counter.sv */
// Top of one pwm channel: enable/disable, period and duty, update path,
// status and event flag.
// Assumes software-side ports are driven from logic on clock_i.
//
// How it works
// - After each period ends the counter restarts at 0x0001, not 0x0000.
// - The first period after a start counts from 0x0000, one count longer.
// - Enabling a center-aligned channel raises the channel event at once.
// - A zero written through the period update register is never applied.
// - A disable before the period elapses keeps enabled-status at 1 for period+1 cycles, in either alignment.
`timescale 1ns/1ps
module pwm_channel_period_counter (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic enable_i,
   input wire logic disable_i,
   input wire logic center_align_select_i,
   input wire logic period_wr_i,
   input wire logic [15:0] period_wdata_i,
   input wire logic update_wr_i,
   input wire logic [15:0] update_wdata_i,
   input wire logic [15:0] duty_i,
   input wire logic event_clr_i,
   output logic pwm_o,
   output logic channel_enabled_status_o,
   output logic event_o,
   output logic [15:0] period_value_o,
   output logic [15:0] count_o
);
   pwm_cnt_if cif ();

   logic run_reg;
   logic status_reg;
   logic lag_reg;
   logic start_reg;
   logic center_reg;
   logic [15:0] period_value_reg;
   logic [15:0] period_update_reg;
   logic upd_pend_reg;
   logic event_reg;
   logic pwm_reg;
   logic [15:0] count_reg;
   logic [15:0] lag_cnt_reg;
   logic [15:0] lag_cnt_next;

   // Enable taken only while stopped; shared by run, status and event logic
   function automatic logic start_hit(input logic en, input logic run);
      return en && !run;
   endfunction

   assign cif.start = start_reg;
   assign cif.run = run_reg;
   assign cif.center = center_reg;
   assign cif.period = period_value_reg;

   pwm_period_counter u_cnt (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .cif(cif)
   );

   // Run and start pulse; alignment is latched at enable time
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         run_reg <= 1'b0;
         start_reg <= 1'b0;
         center_reg <= 1'b0;
      end else if (ce_i) begin
         start_reg <= 1'b0;
         if (start_hit(enable_i, run_reg)) begin
            run_reg <= 1'b1;
            start_reg <= 1'b1;
            center_reg <= center_align_select_i;
         end else if (disable_i) begin
            run_reg <= 1'b0;
         end
      end
   end

   // Status lags a disable by period+1 cycles, in either alignment
   assign lag_cnt_next = lag_cnt_reg + 16'h0001;
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         status_reg <= 1'b0;
         lag_reg <= 1'b0;
         lag_cnt_reg <= pwm_pkg::CNT_FIRST;
      end else if (ce_i) begin
         if (start_hit(enable_i, run_reg)) begin
            status_reg <= 1'b1;
            lag_reg <= 1'b0;
         end else if (disable_i && run_reg) begin
            lag_reg <= 1'b1;
            lag_cnt_reg <= pwm_pkg::CNT_FIRST;
         end else if (lag_reg) begin
            // Counts period+1 cycles, the length of a full left-aligned first period
            if (lag_cnt_reg >= period_value_reg) begin
               lag_reg <= 1'b0;
               status_reg <= 1'b0;
            end else begin
               lag_cnt_reg <= lag_cnt_next;
            end
         end
      end
   end

   // Period register: direct writes apply at once, zero included
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         period_value_reg <= pwm_pkg::PERIOD_RST;
         period_update_reg <= pwm_pkg::PERIOD_RST;
         upd_pend_reg <= 1'b0;
      end else if (ce_i) begin
         if (period_wr_i) begin
            period_value_reg <= period_wdata_i;
            upd_pend_reg <= 1'b0;
         end else if (upd_pend_reg && (cif.period_end || !run_reg)) begin
            period_value_reg <= period_update_reg;
            upd_pend_reg <= 1'b0;
         end
         if (update_wr_i && update_wdata_i != pwm_pkg::ZERO_PERIOD) begin
            period_update_reg <= update_wdata_i;
            upd_pend_reg <= 1'b1;
         end
      end
   end

   // Sticky channel event; a new event wins over a clear
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         event_reg <= 1'b0;
      end else if (ce_i) begin
         if (cif.period_end || (start_hit(enable_i, run_reg) && center_align_select_i)) begin
            event_reg <= 1'b1;
         end else if (event_clr_i) begin
            event_reg <= 1'b0;
         end
      end
   end

   // Output waveform, registered; high while running and count below duty
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         pwm_reg <= 1'b0;
         count_reg <= pwm_pkg::CNT_FIRST;
      end else if (ce_i) begin
         pwm_reg <= run_reg && (cif.count < duty_i);
         count_reg <= cif.count;
      end
   end

   assign pwm_o = pwm_reg;
   assign channel_enabled_status_o = status_reg;
   assign event_o = event_reg;
   assign period_value_o = period_value_reg;
   assign count_o = count_reg;
endmodule

/* File: hw/pwm_period_counter.sv */
// Period counter of one pwm channel, left or center aligned.
// Assumes the control side holds period stable except at period_end.
`timescale 1ns/1ps
module pwm_period_counter (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic ce_i,
   pwm_cnt_if.cnt cif
);
   logic [15:0] count_reg;
   pwm_pkg::dir_t dir_reg;
   logic end_now;

   // Period ends at the top (left) or back at the restart value (center)
   always_comb begin
      // No end on the start edge: a stale count left by the last run is ignored
      if (!cif.run || cif.start) begin
         end_now = 1'b0;
      end else if (cif.center) begin
         end_now = (dir_reg == pwm_pkg::DIR_DOWN) && (count_reg <= pwm_pkg::CNT_RESTART);
      end else begin
         end_now = (count_reg >= cif.period);
      end
   end
   assign cif.period_end = end_now;
   assign cif.count = count_reg;
   assign cif.dir_down = (dir_reg == pwm_pkg::DIR_DOWN);

   // Counter; first period starts at zero, later ones at one
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         count_reg <= pwm_pkg::CNT_FIRST;
         dir_reg <= pwm_pkg::DIR_UP;
      end else if (ce_i) begin
         if (cif.start) begin
            count_reg <= pwm_pkg::CNT_FIRST;
            dir_reg <= pwm_pkg::DIR_UP;
         end else if (cif.run) begin
            if (end_now) begin
               count_reg <= pwm_pkg::CNT_RESTART;
               dir_reg <= pwm_pkg::DIR_UP;
            end else if (cif.center) begin
               case (dir_reg)
                  pwm_pkg::DIR_UP: begin
                     if (count_reg >= cif.period) begin
                        dir_reg <= pwm_pkg::DIR_DOWN;
                        // A zero period turns at zero instead of wrapping
                        if (count_reg != pwm_pkg::CNT_FIRST) begin
                           count_reg <= count_reg - 16'h0001;
                        end
                     end else begin
                        count_reg <= count_reg + 16'h0001;
                     end
                  end
                  pwm_pkg::DIR_DOWN: count_reg <= count_reg - 16'h0001;
                  default: dir_reg <= pwm_pkg::DIR_UP;
               endcase
            end else begin
               count_reg <= count_reg + 16'h0001;
            end
         end
      end
   end
endmodule

/* File: shared/pwm_cnt_if.sv */
// Interface between the channel control and its period counter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface pwm_cnt_if;
   logic start;
   logic run;
   logic center;
   logic [15:0] period;
   logic [15:0] count;
   logic period_end;
   logic dir_down;
   modport ctrl (output start, output run, output center, output period,
      input count, input period_end, input dir_down);
   modport cnt (input start, input run, input center, input period,
      output count, output period_end, output dir_down);
endinterface

/* File: shared/pwm_pkg.sv */
// Package for the pwm channel period counter: widths, reset values, states.
// Assumes a single 250 MHz clock domain and software-side ports without a bus.
package pwm_pkg;
   localparam int CNT_W = 16;
   localparam logic [15:0] CNT_FIRST = 16'h0000;
   localparam logic [15:0] CNT_RESTART = 16'h0001;
   localparam logic [15:0] PERIOD_RST = 16'h0000;
   localparam logic [15:0] DUTY_RST = 16'h0000;
   localparam logic [15:0] ZERO_PERIOD = 16'h0000;
   localparam int CLK_MHZ = 250;

   // Counting direction for center-aligned mode
   typedef enum logic [1:0] {
      DIR_UP = 2'b01,
      DIR_DOWN = 2'b10
   } dir_t;
endpackage
